// ==== spg_pkg.sv ====
// spg_pkg: register map, field positions, reset values and timing for the six-channel pwm
// assumes: plain register port, 16-bit data words, one operation clock
package spg_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_COMPARE_INVERT_REG = 4'h2;
  localparam logic [3:0] ADDR_MOD = 4'h3;
  localparam logic [3:0] ADDR_DTIME = 4'h4;
  localparam logic [3:0] ADDR_PECTL = 4'h5;
  localparam logic [3:0] ADDR_STATUS = 4'h6;
  localparam logic [3:0] ADDR_VAL0 = 4'h8;
  // ----------------------------------------
  // ctrl fields
  // ----------------------------------------
  localparam int CTRL_LOAD_OKAY = 0;
  localparam int CTRL_HALF = 1;
  localparam int CTRL_ENABLE = 2;
  localparam int CTRL_PRSC_LO = 4;
  localparam int CTRL_PRSC_HI = 5;
  // ----------------------------------------
  // config fields
  // ----------------------------------------
  localparam int CFG_EDGE = 0;
  localparam int CFG_INDEP = 1;
  localparam int CFG_TOPNEG = 4;
  localparam int CFG_BOTNEG = 5;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_CONFIG = 16'h0000;
  localparam logic [14:0] RST_MOD = 15'h0000;
  localparam logic [7:0] RST_DTIME = 8'h00;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int DT_PIPE_CYCLES = 2;
endpackage : spg_pkg

// ==== spg_core.sv ====
// spg_core: six-output pwm generator with prescaler, shared counter, deadtime
// assumes: single 250 MHz clock, register strobes one cycle long, read data a cycle later
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module spg_core (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [5:0] pwm_out
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] ctrl_r;
  logic [15:0] config_reg_r;
  logic [5:0] compare_invert_reg_r;
  logic [14:0] counter_modulus_r;
  logic [7:0] deadtime_count_r;
  logic [2:0] edge_place_ctrl_reg_r;
  logic [15:0] channel_value_regs_r [6];
  logic [15:0] rdata_r;
  logic [1:0] prsc_buf_r;
  logic [14:0] mod_buf_r;
  logic [15:0] val_buf_r [6];
  logic [14:0] cnt_r;
  logic down_r;
  logic [2:0] div_r;
  logic [5:0] cmp_r;
  logic [5:0] out_r;
  logic [5:0] pin_r;
  logic [2:0] gen_d_r;
  logic [7:0] dt_cnt_r [3];
  logic load_okay;
  logic enable;
  logic edge_align_sel;
  logic [2:0] pair_independent_bit;
  logic [2:0] top_active_low;
  logic [2:0] bottom_active_low;
  logic [1:0] prescale_sel;
  logic prescale_sel_lo;
  logic prescale_sel_hi;
  logic pwm_tick;
  logic at_top;
  logic at_mid;
  logic period_start;
  logic reload_pt;
  logic do_load;
  logic [2:0] div_nxt;
  logic [14:0] cnt_nxt;
  logic down_nxt;
  logic [2:0] gen;
  logic [5:0] act;

  assign load_okay = ctrl_r[spg_pkg::CTRL_LOAD_OKAY];
  assign enable = ctrl_r[spg_pkg::CTRL_ENABLE];
  assign prescale_sel_lo = ctrl_r[spg_pkg::CTRL_PRSC_LO];
  assign prescale_sel_hi = ctrl_r[spg_pkg::CTRL_PRSC_HI];
  assign prescale_sel = {prescale_sel_hi, prescale_sel_lo};
  assign edge_align_sel = config_reg_r[spg_pkg::CFG_EDGE];
  assign pair_independent_bit = config_reg_r[spg_pkg::CFG_INDEP +: 3];
  assign top_active_low = config_reg_r[spg_pkg::CFG_TOPNEG +: 3] & 3'h7;
  assign bottom_active_low = {3{config_reg_r[spg_pkg::CFG_BOTNEG]}} & 3'h7;

  // value clamp: negative values count as zero
  function automatic logic [14:0] clamp_val(input logic [15:0] v);
    clamp_val = v[15] ? 15'h0000 : v[14:0];
  endfunction : clamp_val

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic wr_ctrl;
  logic [15:0] rd_mux;
  assign wr_ctrl = reg_wr && reg_addr == spg_pkg::ADDR_CTRL;
  always_comb begin
    rd_mux = 16'h0000;
    case (reg_addr)
      spg_pkg::ADDR_CTRL: rd_mux = ctrl_r;
      spg_pkg::ADDR_CONFIG: rd_mux = config_reg_r;
      spg_pkg::ADDR_COMPARE_INVERT_REG: rd_mux = {10'h000, compare_invert_reg_r};
      spg_pkg::ADDR_MOD: rd_mux = {1'b0, counter_modulus_r};
      spg_pkg::ADDR_DTIME: rd_mux = {8'h00, deadtime_count_r};
      spg_pkg::ADDR_PECTL: rd_mux = {13'h0000, edge_place_ctrl_reg_r};
      spg_pkg::ADDR_STATUS: rd_mux = {down_r, cnt_r};
      default: begin
        if (reg_addr >= spg_pkg::ADDR_VAL0 && reg_addr < spg_pkg::ADDR_VAL0 + 4'h6) begin
          rd_mux = channel_value_regs_r[3'(reg_addr - spg_pkg::ADDR_VAL0)];
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 16'h0000;
    end else if (clk_en) begin
      rdata_r <= reg_rd ? rd_mux : 16'h0000;
    end
  end
  assign reg_rdata = rdata_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= spg_pkg::RST_CTRL;
      config_reg_r <= spg_pkg::RST_CONFIG;
      compare_invert_reg_r <= 6'h00;
      counter_modulus_r <= spg_pkg::RST_MOD;
      deadtime_count_r <= spg_pkg::RST_DTIME;
      edge_place_ctrl_reg_r <= 3'h0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata & 16'h0037;
      end else if (do_load) begin
        ctrl_r[spg_pkg::CTRL_LOAD_OKAY] <= 1'b0;
      end
      if (reg_wr && reg_addr == spg_pkg::ADDR_CONFIG) config_reg_r <= reg_wdata & 16'h003f;
      if (reg_wr && reg_addr == spg_pkg::ADDR_COMPARE_INVERT_REG) compare_invert_reg_r <= reg_wdata[5:0];
      if (reg_wr && reg_addr == spg_pkg::ADDR_MOD) counter_modulus_r <= reg_wdata[14:0];
      if (reg_wr && reg_addr == spg_pkg::ADDR_DTIME) deadtime_count_r <= reg_wdata[7:0];
      if (reg_wr && reg_addr == spg_pkg::ADDR_PECTL) edge_place_ctrl_reg_r <= reg_wdata[2:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_val
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          channel_value_regs_r[gi] <= 16'h0000;
          val_buf_r[gi] <= 16'h0000;
        end else if (clk_en) begin
          if (reg_wr && reg_addr == spg_pkg::ADDR_VAL0 + 4'(gi)) begin
            channel_value_regs_r[gi] <= reg_wdata;
          end
          if (do_load) val_buf_r[gi] <= channel_value_regs_r[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // prescaler and counter
  // ----------------------------------------
  // pwm_tick fires once per 1,2,4 or 8 clocks from the buffered select
  assign pwm_tick = enable && ((div_r & ((3'h1 << prsc_buf_r) - 3'h1)) == 3'h0);
  assign div_nxt = enable ? div_r + 3'h1 : 3'h0;
  // zero modulus is treated as one so the counter cannot stall
  logic [14:0] mod_eff;
  assign mod_eff = (mod_buf_r == 15'h0000) ? 15'h0001 : mod_buf_r;
  assign at_top = !edge_align_sel && !down_r && cnt_r >= mod_eff;
  assign at_mid = at_top;
  assign period_start = edge_align_sel ? (cnt_r >= mod_eff - 15'h0001)
                                       : (down_r && cnt_r <= 15'h0001);
  assign reload_pt = pwm_tick && (period_start ||
                     (at_mid && ctrl_r[spg_pkg::CTRL_HALF]));
  assign do_load = (reload_pt || (enable && cnt_r == 15'h0000 && !down_r && div_r == 3'h0))
                   && load_okay;

  always_comb begin
    cnt_nxt = cnt_r;
    down_nxt = down_r;
    if (!enable) begin
      cnt_nxt = 15'h0000;
      down_nxt = 1'b0;
    end else if (pwm_tick) begin
      if (edge_align_sel) begin
        down_nxt = 1'b0;
        cnt_nxt = period_start ? 15'h0000 : cnt_r + 15'h0001;
      end else if (at_top) begin
        down_nxt = 1'b1;
        cnt_nxt = cnt_r - 15'h0001;
      end else if (period_start) begin
        down_nxt = 1'b0;
        cnt_nxt = 15'h0000;
      end else begin
        cnt_nxt = down_r ? cnt_r - 15'h0001 : cnt_r + 15'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 15'h0000;
      down_r <= 1'b0;
      div_r <= 3'h0;
      prsc_buf_r <= 2'h0;
      mod_buf_r <= 15'h0000;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
      down_r <= down_nxt;
      div_r <= do_load ? 3'h0 : div_nxt;
      if (do_load) begin
        prsc_buf_r <= prescale_sel;
        mod_buf_r <= counter_modulus_r;
      end
    end
  end

  // ----------------------------------------
  // compare outputs
  // ----------------------------------------
  // the compare output is a set/clear latch around the counter, so one comparator
  // per edge suffices (>= or <= in center mode); inversion is applied at the latch output
  logic [5:0] cmp_nxt;
  logic [5:0] cmp_sel_val_hi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_cmp
      logic [14:0] v;
      logic [14:0] vu;
      // pairs in complementary center mode use odd value rising (counting down), even falling (counting up)
      assign vu = clamp_val(val_buf_r[gi]);
      assign v = (!pair_independent_bit[gi/2] && !edge_align_sel)
                 ? clamp_val(val_buf_r[down_r ? (gi | 1) : (gi & 4'he)]) : vu;
      always_comb begin
        cmp_nxt[gi] = cmp_r[gi];
        if (edge_align_sel) begin
          // raw pulse high from period start until count reaches value
          if (cnt_r == 15'h0000 || period_start) cmp_nxt[gi] = vu != 15'h0000;
          if (cnt_r == vu - 15'h0001 && !period_start) cmp_nxt[gi] = 1'b0;
          if (vu >= mod_eff) cmp_nxt[gi] = 1'b1;
        end else if (down_r) begin
          // the latch output lags one tick, so set one count early to keep width 2*value
          if (v >= cnt_r) cmp_nxt[gi] = 1'b1;
        end else begin
          if (v <= cnt_r) cmp_nxt[gi] = 1'b0;
        end
        if (v >= mod_eff && !edge_align_sel) cmp_nxt[gi] = 1'b1;
        if (v == 15'h0000 && !edge_align_sel) cmp_nxt[gi] = 1'b0;
      end
      assign cmp_sel_val_hi[gi] = cmp_r[gi] ^ compare_invert_reg_r[gi];
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_r <= 6'h00;
    end else if (clk_en) begin
      if (!enable) cmp_r <= 6'h00;
      else if (pwm_tick) cmp_r <= cmp_nxt;
    end
  end

  // ----------------------------------------
  // pairing, deadtime and polarity
  // ----------------------------------------
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pair
      logic even_p;
      logic odd_p;
      logic dt_busy;
      assign even_p = cmp_sel_val_hi[2*gi];
      assign odd_p = cmp_sel_val_hi[2*gi+1];
      // the xor lets a pulse straddle the period boundary
      assign gen[gi] = (edge_align_sel && edge_place_ctrl_reg_r[gi]) ? (even_p ^ odd_p)
                       : even_p;
      assign dt_busy = dt_cnt_r[gi] != 8'h00;
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          dt_cnt_r[gi] <= 8'h00;
          gen_d_r[gi] <= 1'b0;
        end else if (clk_en) begin
          gen_d_r[gi] <= gen[gi];
          if (gen[gi] != gen_d_r[gi]) dt_cnt_r[gi] <= deadtime_count_r;
          else if (dt_busy && pwm_tick) dt_cnt_r[gi] <= dt_cnt_r[gi] - 8'h01;
        end
      end
      always_comb begin
        if (pair_independent_bit[gi]) begin
          act[2*gi] = even_p;
          act[2*gi+1] = odd_p;
        end else begin
          // the old side holds through the change cycle; the count then blanks both
          act[2*gi] = gen_d_r[gi] && !dt_busy;
          act[2*gi+1] = !gen_d_r[gi] && !dt_busy;
        end
      end
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          out_r[2*gi +: 2] <= 2'h0;
        end else if (clk_en) begin
          out_r[2*gi] <= act[2*gi] ^ top_active_low[gi];
          out_r[2*gi+1] <= act[2*gi+1] ^ bottom_active_low[gi];
        end
      end
    end
  endgenerate

  // second stage of the two-clock deadtime path
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_r <= 6'h00;
    end else if (clk_en) begin
      pin_r <= out_r;
    end
  end
  assign pwm_out = pin_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  load_clears_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && do_load && !wr_ctrl) |=> !load_okay)
    else $error("load okay did not clear");
  cnt_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cnt_r <= mod_eff || !enable || do_load || $past(do_load))
    else $error("counter beyond modulus");
  pipe_two_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clk_en && $past(clk_en) |-> pin_r == $past(out_r))
    else $error("pin stage mismatch");
  dt_inactive_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!pair_independent_bit[0] && dt_cnt_r[0] != 8'h00) |-> !act[0] && !act[1])
    else $error("pair active during deadtime");
  no_overlap_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !pair_independent_bit[1] |-> !(act[2] && act[3]))
    else $error("complementary overlap");
  dt_load_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && gen[2] != gen_d_r[2]) |=> dt_cnt_r[2] == $past(deadtime_count_r))
    else $error("deadtime not loaded");
  edge_up_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    edge_align_sel |-> !down_r || !$past(edge_align_sel))
    else $error("edge mode counting down");
  prsc_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (clk_en && !do_load) |=> prsc_buf_r == $past(prsc_buf_r))
    else $error("prescale changed without load");
endmodule : spg_core
`default_nettype wire

// ==== spg_gate_drv.sv ====
// spg_gate_drv: gate driver model for three top/bottom transistor legs
// assumes: pins carry output polarity; tb says which pairs are complementary
`timescale 1ns/1ns
`default_nettype none
module spg_gate_drv (
  input wire logic sys_clk,
  input wire logic [5:0] pwm_out,
  input wire logic top_low,
  input wire logic bot_low,
  input wire logic [2:0] pair_comp,
  output var int shoot_cnt
);
  // ----------------------------------------
  // conduction per transistor
  // ----------------------------------------
  logic [5:0] on_w;
  assign on_w = pwm_out ^ {3{bot_low, top_low}};
  initial shoot_cnt = 0;
  // only a complementary pair shares one leg, so only it can short the rail
  always @(negedge sys_clk) begin
    for (int p = 0; p < 3; p++) begin
      if (pair_comp[p] && on_w[2*p] === 1'b1 && on_w[2*p+1] === 1'b1) begin
        shoot_cnt++;
      end
    end
  end
endmodule : spg_gate_drv
`default_nettype wire

// ==== tb.sv ====
// tb: self-checking bench for spg_core, duty measured as high cycles over whole periods
// assumes: prescale 1 unless set, so deadtime ticks equal clock cycles
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic sys_clk, rst_b, clk_en, reg_wr, reg_rd, top_low;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_v;
  logic [5:0] pwm_out;
  logic [2:0] pair_comp;
  int err_count, checks_done, cyc, shoot_cnt;
  int cnt [6];
  spg_core dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pwm_out(pwm_out));
  spg_gate_drv drv (.sys_clk(sys_clk), .pwm_out(pwm_out), .top_low(top_low),
    .bot_low(1'b0), .pair_comp(pair_comp), .shoot_cnt(shoot_cnt));
  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    rd_v = reg_rdata;
  endtask : rd
  task automatic meas(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      @(negedge sys_clk);
      for (int i = 0; i < 6; i++) cnt[i] += int'(pwm_out[i] === 1'b1);
    end
  endtask : meas
  // stop, program, then enable with load okay so the buffers take the new set
  task automatic start(input logic [15:0] cfg, input logic [14:0] md, input logic [5:0] inv,
      input logic [15:0] ctl);
    wr(spg_pkg::ADDR_CTRL, 16'h0000);
    wr(spg_pkg::ADDR_CONFIG, cfg);
    wr(spg_pkg::ADDR_MOD, {1'b0, md});
    wr(spg_pkg::ADDR_COMPARE_INVERT_REG, {10'h000, inv});
    wr(spg_pkg::ADDR_CTRL, ctl | 16'h0005);
    repeat (100) @(posedge sys_clk);
  endtask : start
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(spg_pkg::ADDR_CTRL);
    check("ctrl reset", rd_v, spg_pkg::RST_CTRL);
    rd(spg_pkg::ADDR_CONFIG);
    check("config reset", rd_v, spg_pkg::RST_CONFIG);
    wr(spg_pkg::ADDR_MOD, 16'hffff);
    rd(spg_pkg::ADDR_MOD);
    check("modulus width", rd_v, 16'h7fff);
    rd(4'h7);
    check("unmapped read", rd_v, 16'h0000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_prescale();
    for (int s = 0; s < 4; s++) begin
      wr(spg_pkg::ADDR_VAL0, 16'h0004);
      start(16'h000f, 15'h000a, 6'h00, 16'(s << spg_pkg::CTRL_PRSC_LO));
      meas(100 << s);
      check("edge width per divisor", 16'(cnt[0]), 16'(40 << s));
    end
    $display("test prescale done");
  endtask : t_prescale
  task automatic t_buffer();
    wr(spg_pkg::ADDR_VAL0, 16'h0004);
    start(16'h000f, 15'h000a, 6'h00, 16'h0000);
    wr(spg_pkg::ADDR_CTRL, 16'h0014);
    repeat (50) @(posedge sys_clk);
    meas(100);
    check("prescale held back", 16'(cnt[0]), 16'h0028);
    wr(spg_pkg::ADDR_CTRL, 16'h0015);
    repeat (100) @(posedge sys_clk);
    rd(spg_pkg::ADDR_CTRL);
    check("load okay cleared", {15'h0000, rd_v[0]}, 16'h0000);
    meas(200);
    check("prescale applied", 16'(cnt[0]), 16'h0050);
    $display("test buffer done");
  endtask : t_buffer
  task automatic t_center();
    logic [15:0] v [6];
    logic [15:0] e [6];
    v = '{16'h0003, 16'h0003, 16'h8000, 16'h000a, 16'h0000, 16'h0005};
    e = '{16'h003c, 16'h008c, 16'h0000, 16'h00c8, 16'h0000, 16'h0064};
    for (int i = 0; i < 6; i++) wr(spg_pkg::ADDR_VAL0 + 4'(i), v[i]);
    start(16'h000e, 15'h000a, 6'h02, 16'h0000);
    meas(200);
    for (int i = 0; i < 6; i++) begin
      check("center width", 16'(cnt[i]), e[i]);
    end
    $display("test center done");
  endtask : t_center
  // pair 0 complementary; top and bottom high counts over n cycles
  task automatic t_comp(input logic [15:0] cfg, input logic [14:0] md, input logic [15:0] v0,
      input logic [15:0] v1, input logic [15:0] pec, input int n, input int e0, input int e1);
    int s0;
    pair_comp <= 3'b001;
    top_low <= cfg[spg_pkg::CFG_TOPNEG];
    wr(spg_pkg::ADDR_VAL0, v0);
    wr(spg_pkg::ADDR_VAL0 + 4'h1, v1);
    wr(spg_pkg::ADDR_DTIME, 16'h0002);
    wr(spg_pkg::ADDR_PECTL, pec);
    start(cfg, md, 6'h00, 16'h0000);
    s0 = shoot_cnt;
    meas(n);
    check("top pin", 16'(cnt[0]), 16'(e0));
    check("bottom pin", 16'(cnt[1]), 16'(e1));
    check("leg overlap", 16'(shoot_cnt - s0), 16'h0000);
    $display("test complementary done");
  endtask : t_comp
  // ----------------------------------------
  // closing
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    top_low = 1'b0;
    pair_comp = 3'b000;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_prescale();
    t_buffer();
    t_center();
    t_comp(16'h000d, 15'h0014, 16'h0008, 16'h0008, 16'h0000, 400, 120, 200);
    t_comp(16'h000c, 15'h000a, 16'h0002, 16'h0004, 16'h0000, 200, 40, 120);
    t_comp(16'h000d, 15'h0014, 16'h0004, 16'h000e, 16'h0001, 400, 160, 160);
    t_comp(16'h001d, 15'h0014, 16'h0008, 16'h0008, 16'h0000, 400, 280, 200);
    stop_test();
  end
endmodule : tb
`default_nettype wire
